// ===== core/ivfr_input_voltage_fault_response.sv
// Input-voltage limits, supervision and under-voltage fault response
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module ivfr_input_voltage_fault_response
    import ivfr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command port: limit and action registers by command code
    input wire ivfr_cmd_s cmd,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic cmd_unsupported,
    // Supervision inputs
    input wire logic [15:0] vin_measured,
    input wire logic [15:0] delay_unit_cycles,
    input wire logic hybrid_ratio_regulation,
    // Power control
    input wire logic op_enable,
    input wire logic other_fault_shutdown,
    input wire logic clear_faults,
    // Status
    output ivfr_status_s status
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ivfr_regs_s regs;
        ivfr_state_e state;
        logic [2:0] attempts;
        logic tmr_start;
        logic tmr_abort;
        logic [15:0] rd_data;
        logic rd_valid;
        logic unsupported;
        ivfr_status_s status;
    } ivfr_core_s;

    ivfr_core_s r, next_r;

    // ------------------------------------------------------------
    // Limit comparison
    // ------------------------------------------------------------
    logic signed [FIX_W-1:0] vin_fix;
    logic signed [FIX_W-1:0] lim_fix [NUM_LIMITS];
    logic [15:0] lim_word [NUM_LIMITS];

    always_comb begin
        lim_word[LIM_OV_WARN] = r.regs.ov_warn;
        lim_word[LIM_UV_WARN] = r.regs.uv_warn;
        lim_word[LIM_UV_FAULT] = r.regs.uv_fault;
    end

    ivfr_linear_fix u_vin_fix (
        .lin(vin_measured),
        .fix(vin_fix)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_lim
            // Limits held as linear words, compared after conversion
            ivfr_linear_fix u_lim_fix (
                .lin(lim_word[gi]),
                .fix(lim_fix[gi])
            );
        end
    endgenerate

    logic fault_now;
    logic uv_warn_now;
    logic ov_warn_now;

    always_comb begin
        fault_now = vin_fix < lim_fix[LIM_UV_FAULT];
        uv_warn_now = vin_fix < lim_fix[LIM_UV_WARN];
        ov_warn_now = vin_fix > lim_fix[LIM_OV_WARN];
    end

    // ------------------------------------------------------------
    // Delay timer
    // ------------------------------------------------------------
    logic tmr_done;

    ivfr_delay_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .start(r.tmr_start),
        .abort(r.tmr_abort),
        .code(r.regs.action[DELAY_MSB:DELAY_LSB]),
        .unit_cycles(delay_unit_cycles),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] attempts_inc;

    always_comb begin
        resp = r.regs.action[RESP_MSB:RESP_LSB];
        retries = r.regs.action[RETRY_MSB:RETRY_LSB];
        attempts_inc = r.attempts + 3'h1;
        next_r = r;
        next_r.tmr_start = 1'b0;
        next_r.tmr_abort = 1'b0;
        next_r.rd_valid = 1'b0;
        next_r.unsupported = 1'b0;

        // Command writes and reads
        if (cmd.wr) begin
            unique case (cmd.code)
                CMD_IN_OV_WARN_LIMIT: next_r.regs.ov_warn = cmd.wdata;
                CMD_IN_UV_WARN_LIMIT: next_r.regs.uv_warn = cmd.wdata;
                CMD_IN_UV_FAULT_LIMIT: next_r.regs.uv_fault = cmd.wdata;
                CMD_IN_UV_FAULT_ACTION: next_r.regs.action = cmd.wdata[7:0];
                default: next_r.unsupported = 1'b1;
            endcase
        end else if (cmd.rd) begin
            next_r.rd_valid = 1'b1;
            unique case (cmd.code)
                CMD_IN_OV_WARN_LIMIT: next_r.rd_data = r.regs.ov_warn;
                CMD_IN_UV_WARN_LIMIT: next_r.rd_data = r.regs.uv_warn;
                CMD_IN_UV_FAULT_LIMIT: next_r.rd_data = r.regs.uv_fault;
                CMD_IN_UV_FAULT_ACTION: next_r.rd_data = {8'h00, r.regs.action};
                default: begin
                    next_r.rd_data = 16'h0000;
                    next_r.unsupported = 1'b1;
                end
            endcase
        end

        // Response state machine
        if (!op_enable || other_fault_shutdown) begin
            // Command off or another fault ends any retry sequence
            next_r.state = ST_OFF;
            next_r.status.output_enable = 1'b0;
            next_r.tmr_abort = 1'b1;
            next_r.attempts = 3'h0;
        end else begin
            unique case (r.state)
                ST_OFF: begin
                    next_r.state = ST_RUN;
                    next_r.status.output_enable = 1'b1;
                end
                ST_RUN: begin
                    if (fault_now) begin
                        next_r.attempts = 3'h0;
                        unique case (resp)
                            RESP_IGNORE: next_r.state = ST_RUN;
                            RESP_CONTINUE: begin
                                // Keep running while the delay elapses
                                next_r.state = ST_CONTINUE;
                                next_r.tmr_start = 1'b1;
                            end
                            RESP_DISABLE_RETRY: begin
                                next_r.status.output_enable = 1'b0;
                                if (retries == RETRY_NONE) begin
                                    next_r.state = ST_LATCHED;
                                end else begin
                                    next_r.state = ST_RETRY_WAIT;
                                    next_r.tmr_start = 1'b1;
                                end
                            end
                            RESP_DISABLE_RESUME: begin
                                next_r.status.output_enable = 1'b0;
                                next_r.state = ST_HOLD;
                            end
                        endcase
                    end
                end
                ST_CONTINUE: begin
                    if (!fault_now) begin
                        next_r.state = ST_RUN;
                        next_r.tmr_abort = 1'b1;
                    end else if (tmr_done) begin
                        // Fault outlived the delay: shut down, follow retries
                        next_r.status.output_enable = 1'b0;
                        if (retries == RETRY_NONE) begin
                            next_r.state = ST_LATCHED;
                        end else begin
                            next_r.state = ST_RETRY_WAIT;
                            next_r.tmr_start = 1'b1;
                        end
                    end
                end
                ST_RETRY_WAIT: begin
                    if (tmr_done) begin
                        // An attempt fails when the input is still low
                        if (!fault_now) begin
                            next_r.state = ST_RUN;
                            next_r.status.output_enable = 1'b1;
                        end else if (retries == RETRY_FOREVER) begin
                            next_r.tmr_start = 1'b1;
                        end else if (attempts_inc < retries) begin
                            next_r.attempts = attempts_inc;
                            next_r.tmr_start = 1'b1;
                        end else begin
                            next_r.attempts = attempts_inc;
                            next_r.state = ST_LATCHED;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!fault_now) begin
                        next_r.state = ST_RUN;
                        next_r.status.output_enable = 1'b1;
                    end
                end
                ST_LATCHED: begin
                    if (clear_faults) begin
                        next_r.state = ST_RUN;
                        next_r.status.output_enable = 1'b1;
                        next_r.attempts = 3'h0;
                    end
                end
                default: begin
                    next_r.state = ST_OFF;
                    next_r.status.output_enable = 1'b0;
                end
            endcase
        end

        // Sticky fault flag: a new fault wins over a clear
        if (fault_now) begin
            next_r.status.uv_fault_flag = 1'b1;
        end else if (clear_faults) begin
            next_r.status.uv_fault_flag = 1'b0;
        end
        next_r.status.uv_fault_now = fault_now;
        next_r.status.uv_warn = uv_warn_now;
        next_r.status.ov_warn = ov_warn_now;
        // Same comparison feeds the hybrid-ratio threshold when enabled
        next_r.status.hrr_below = hybrid_ratio_regulation && uv_warn_now;
        next_r.status.retry_active = (next_r.state == ST_RETRY_WAIT);
        next_r.status.attempts = next_r.attempts;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.regs.ov_warn <= RST_OV_WARN;
            r.regs.uv_warn <= RST_UV_WARN;
            r.regs.uv_fault <= RST_UV_FAULT;
            r.regs.action <= RST_ACTION;
            r.state <= ST_OFF;
        end else begin
            r <= next_r;
        end
    end

    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign cmd_unsupported = r.unsupported;
    assign status = r.status;
endmodule
`default_nettype wire

// ===== core/ivfr_pkg.sv
// Constants and carrier types for the input-voltage fault response block
package ivfr_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_IN_OV_WARN_LIMIT = 8'h57;
    localparam logic [7:0] CMD_IN_UV_WARN_LIMIT = 8'h58;
    localparam logic [7:0] CMD_IN_UV_FAULT_LIMIT = 8'h59;
    localparam logic [7:0] CMD_IN_UV_FAULT_ACTION = 8'h5A;
    // ------------------------------------------------------------
    // Reset values (limits in linear format, volts; action byte)
    // ------------------------------------------------------------
    localparam logic [15:0] RST_OV_WARN = 16'hDB20;
    localparam logic [15:0] RST_UV_WARN = 16'hD200;
    localparam logic [15:0] RST_UV_FAULT = 16'hD1C0;
    localparam logic [7:0] RST_ACTION = 8'hC0;
    // ------------------------------------------------------------
    // Fault action byte fields
    // ------------------------------------------------------------
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_CONTINUE = 2'h1;
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] RESP_DISABLE_RESUME = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // ------------------------------------------------------------
    // Linear format layout and fixed-point conversion
    // ------------------------------------------------------------
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MANT_MSB = 10;
    localparam int FIX_FRAC = 16;
    localparam int FIX_W = 48;
    localparam int NUM_LIMITS = 3;
    localparam int LIM_OV_WARN = 0;
    localparam int LIM_UV_WARN = 1;
    localparam int LIM_UV_FAULT = 2;
    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF, ST_RUN, ST_CONTINUE, ST_RETRY_WAIT, ST_LATCHED, ST_HOLD
    } ivfr_state_e;

    typedef struct packed {
        logic [15:0] ov_warn;
        logic [15:0] uv_warn;
        logic [15:0] uv_fault;
        logic [7:0] action;
    } ivfr_regs_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] wdata;
    } ivfr_cmd_s;

    typedef struct packed {
        logic output_enable;
        logic uv_fault_flag;
        logic uv_fault_now;
        logic uv_warn;
        logic ov_warn;
        logic hrr_below;
        logic retry_active;
        logic [2:0] attempts;
    } ivfr_status_s;
endpackage

// ===== core/ivfr_linear_fix.sv
// Linear-format word to signed fixed-point value, for limit comparison
`timescale 1ns/10ps
`default_nettype none
module ivfr_linear_fix
    import ivfr_pkg::*;
(
    // Linear word in
    input wire logic [15:0] lin,
    // Fixed-point out, FIX_FRAC fractional bits
    output logic signed [FIX_W-1:0] fix
);
    logic signed [4:0] exp_s;
    logic signed [10:0] mant_s;
    logic [5:0] shift;

    always_comb begin
        exp_s = signed'(lin[LIN_EXP_MSB:LIN_EXP_LSB]);
        mant_s = signed'(lin[LIN_MANT_MSB:0]);
        // Exponent -16..15 maps onto a left shift of 0..31
        shift = 6'(signed'(exp_s) + 6'sd16);
        fix = FIX_W'(signed'(mant_s)) <<< shift;
    end
endmodule
`default_nettype wire

// ===== core/ivfr_delay_timer.sv
// Scaled delay timer: 2**code time units, each unit_cycles clocks long
`timescale 1ns/10ps
`default_nettype none
module ivfr_delay_timer
    import ivfr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic [2:0] code,
    input wire logic [15:0] unit_cycles,
    // Result
    output logic done
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [15:0] cnt;
        logic [7:0] units_left;
    } ivfr_tmr_s;

    ivfr_tmr_s r, next_r;
    logic [15:0] reload;

    always_comb begin
        // A zero unit length would stall; treat it as one clock
        reload = (unit_cycles == 16'h0000) ? 16'h0000 : unit_cycles - 16'h0001;
        next_r = r;
        next_r.done = 1'b0;
        if (abort) begin
            next_r.busy = 1'b0;
        end else if (start) begin
            next_r.busy = 1'b1;
            next_r.cnt = reload;
            next_r.units_left = 8'h01 << code;
        end else if (r.busy) begin
            if (r.cnt != 16'h0000) begin
                next_r.cnt = r.cnt - 16'h0001;
            end else if (r.units_left == 8'h01) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.units_left = r.units_left - 8'h01;
                next_r.cnt = reload;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule
`default_nettype wire

// ===== tb/ivfr_props.sv
// Concurrent checks on the ports of the input-voltage fault response block
`timescale 1ns/10ps
`default_nettype none
module ivfr_props
    import ivfr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command port
    input wire ivfr_cmd_s cmd,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_unsupported,
    // Supervision and power control
    input wire logic [15:0] vin_measured,
    input wire logic [15:0] delay_unit_cycles,
    input wire logic hybrid_ratio_regulation,
    input wire logic op_enable,
    input wire logic other_fault_shutdown,
    input wire logic clear_faults,
    input wire ivfr_status_s status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow of the action byte, since the checker cannot see the register
    logic [7:0] act;
    logic [2:0] prev_att;
    logic [15:0] gap;
    logic mapped;
    int span;
    assign mapped = (cmd.code >= CMD_IN_OV_WARN_LIMIT) && (cmd.code <= CMD_IN_UV_FAULT_ACTION);
    always_comb begin
        span = ((delay_unit_cycles == 16'h0000) ? 1 : int'(delay_unit_cycles)) * (1 << act[2:0]) + 2;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            act <= RST_ACTION;
            prev_att <= 3'h0;
            gap <= 16'h0000;
        end else begin
            if (cmd.wr && cmd.code == CMD_IN_UV_FAULT_ACTION) begin
                act <= cmd.wdata[7:0];
            end
            prev_att <= status.attempts;
            gap <= (status.attempts != prev_att) ? 16'h0000 : gap + 16'h0001;
        end
    end
    sequence s_fault_rise;
        $rose(status.uv_fault_now) && $past(status.output_enable) && $past(op_enable) &&
            !$past(other_fault_shutdown);
    endsequence
    sequence s_stay_on;
        status.output_enable ##1 status.output_enable;
    endsequence
    property p_rd_answer; cmd.rd && !cmd.wr |=> rd_valid; endproperty
    property p_unsup; cmd.wr || cmd.rd |=> cmd_unsupported != $past(mapped); endproperty
    property p_ignore;
        act[7:6] == RESP_IGNORE && status.output_enable && op_enable && !other_fault_shutdown
            |=> status.output_enable;
    endproperty
    property p_continue; (act[7:6] == RESP_CONTINUE) ##0 s_fault_rise |-> s_stay_on; endproperty
    property p_disable; (act[7] == 1'b1) ##0 s_fault_rise |-> !status.output_enable; endproperty
    property p_resume;
        act[7:6] == RESP_DISABLE_RESUME && $fell(status.uv_fault_now) && $past(op_enable) &&
            !$past(other_fault_shutdown) |-> status.output_enable;
    endproperty
    property p_no_retry;
        act[7:6] == RESP_DISABLE_RETRY && act[5:3] == RETRY_NONE && !status.output_enable &&
            status.uv_fault_flag && op_enable && $past(op_enable) && !other_fault_shutdown &&
            !$past(other_fault_shutdown) && !clear_faults |=> !status.output_enable;
    endproperty
    property p_retry_limit;
        act[7:6] == RESP_DISABLE_RETRY && act[5:3] != RETRY_NONE && act[5:3] != RETRY_FOREVER &&
            status.attempts == act[5:3] && status.attempts != prev_att
            |-> !status.retry_active && !status.output_enable;
    endproperty
    property p_forever;
        act[5:3] == RETRY_FOREVER && status.retry_active && op_enable && !other_fault_shutdown
            |=> status.retry_active || status.output_enable;
    endproperty
    property p_cmd_off;
        !op_enable || other_fault_shutdown |=> !status.output_enable && !status.retry_active;
    endproperty
    property p_interval;
        status.retry_active && status.attempts == prev_att + 3'h1 && prev_att != 3'h0
            |-> int'(gap) + 1 == span;
    endproperty
    property p_hrr_off; !hybrid_ratio_regulation |=> !status.hrr_below; endproperty
    property p_sticky; status.uv_fault_now |-> status.uv_fault_flag; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_unsup: assert property (p_unsup) else $error("unsupported flag wrong");
    a_ignore: assert property (p_ignore) else $error("output dropped on ignore");
    a_continue: assert property (p_continue) else $error("output dropped early");
    a_disable: assert property (p_disable) else $error("output not disabled");
    a_resume: assert property (p_resume) else $error("output not resumed");
    a_no_retry: assert property (p_no_retry) else $error("restart without retry");
    a_retry_limit: assert property (p_retry_limit) else $error("retry count overrun");
    a_forever: assert property (p_forever) else $error("endless retry stopped");
    a_cmd_off: assert property (p_cmd_off) else $error("output on while commanded off");
    a_interval: assert property (p_interval) else $error("retry interval wrong");
    a_hrr_off: assert property (p_hrr_off) else $error("hrr flag while disabled");
    a_sticky: assert property (p_sticky) else $error("fault flag not set");
endmodule
`default_nettype wire

// ===== tb/ivfr_host.sv
// Host controller model driving the command port
`timescale 1ns/10ps
`default_nettype none
module ivfr_host
    import ivfr_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Command port
    output var ivfr_cmd_s cmd,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_unsupported
);
    initial cmd = '0;
    // One command; idle cycles first to mimic a slow host
    task automatic put(input logic w, input logic [7:0] c, input logic [15:0] d, input int idle,
                       output logic [15:0] q, output logic v, output logic u);
        repeat (idle) @(posedge mclk);
        @(posedge mclk);
        cmd <= '{w, !w, c, d};
        @(posedge mclk);
        // Released fields show garbage, not the last value
        cmd <= '{1'b0, 1'b0, ~c, ~d};
        #1;
        q = rd_data;
        v = rd_valid;
        u = cmd_unsupported;
    endtask
endmodule
`default_nettype wire

// ===== tb/test_ivfr_input_voltage_fault_response.sv
// Testbench for the input-voltage fault response block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_ivfr_input_voltage_fault_response import ivfr_pkg::*;;
    localparam logic [15:0] V_NORM = 16'h000C;
    localparam logic [15:0] V_LOW = 16'h0004;
    localparam logic [15:0] V_DIP = 16'h0009;
    localparam logic [15:0] V_HIGH = 16'h0019;
    logic mclk, rst, rd_valid, cmd_unsupported, hybrid_ratio_regulation;
    logic op_enable, other_fault_shutdown, clear_faults;
    logic [15:0] rd_data, vin_measured, delay_unit_cycles;
    ivfr_cmd_s cmd;
    ivfr_status_s status;
    int errors = 0;
    int checks = 0;
    int n;
    logic [7:0] codes [4] = '{CMD_IN_OV_WARN_LIMIT, CMD_IN_UV_WARN_LIMIT,
                              CMD_IN_UV_FAULT_LIMIT, CMD_IN_UV_FAULT_ACTION};
    logic [15:0] limits [4] = '{16'h0014, 16'h000A, 16'h0008, 16'h00C0};
    ivfr_input_voltage_fault_response uut (.mclk, .rst, .cmd, .rd_data, .rd_valid,
        .cmd_unsupported, .vin_measured, .delay_unit_cycles, .hybrid_ratio_regulation,
        .op_enable, .other_fault_shutdown, .clear_faults, .status);
    ivfr_host host (.mclk, .cmd, .rd_data, .rd_valid, .cmd_unsupported);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] q;
        logic v, u;
        host.put(1'b1, c, d, 0, q, v, u);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic eu);
        logic [15:0] q;
        logic v, u;
        host.put(1'b0, c, 16'h0000, 2, q, v, u);
        `CHK(v, 1'b1)
        `CHK(q, e)
        `CHK(u, eu)
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic set_vin(input logic [15:0] v);
        @(posedge mclk);
        vin_measured <= v;
    endtask
    task automatic clear;
        @(posedge mclk);
        clear_faults <= 1'b1;
        @(posedge mclk);
        clear_faults <= 1'b0;
        cyc(3);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        test_done;
    end
    initial begin
        rst = 1'b1;
        vin_measured = V_NORM;
        delay_unit_cycles = 16'h0002;
        hybrid_ratio_regulation = 1'b0;
        op_enable = 1'b0;
        other_fault_shutdown = 1'b0;
        clear_faults = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(CMD_IN_OV_WARN_LIMIT, RST_OV_WARN, 1'b0);
        rd(CMD_IN_UV_WARN_LIMIT, RST_UV_WARN, 1'b0);
        rd(CMD_IN_UV_FAULT_LIMIT, RST_UV_FAULT, 1'b0);
        rd(CMD_IN_UV_FAULT_ACTION, {8'h00, RST_ACTION}, 1'b0);
        rd(8'h5B, 16'h0000, 1'b1);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) wr(codes[i], limits[i]);
        for (int i = 0; i < 4; i++) rd(codes[i], limits[i], 1'b0);
        @(posedge mclk);
        op_enable <= 1'b1;
        cyc(3);
        `CHK(status.output_enable, 1'b1)
        set_vin(V_DIP);
        cyc(2);
        `CHK({status.uv_warn, status.uv_fault_now, status.hrr_below}, 3'b100)
        @(posedge mclk);
        hybrid_ratio_regulation <= 1'b1;
        cyc(2);
        `CHK(status.hrr_below, 1'b1)
        set_vin(V_HIGH);
        cyc(2);
        `CHK({status.ov_warn, status.uv_warn, status.hrr_below}, 3'b100)
        $display("test warnings done");
        wr(CMD_IN_UV_FAULT_ACTION, 16'h0000);
        set_vin(V_LOW);
        cyc(20);
        `CHK({status.output_enable, status.uv_fault_flag}, 2'b11)
        set_vin(V_NORM);
        clear;
        `CHK(status.uv_fault_flag, 1'b0)
        wr(CMD_IN_UV_FAULT_ACTION, 16'h00C0);
        set_vin(V_LOW);
        cyc(3);
        `CHK(status.output_enable, 1'b0)
        set_vin(V_NORM);
        cyc(3);
        `CHK(status.output_enable, 1'b1)
        $display("test ignore_resume done");
        wr(CMD_IN_UV_FAULT_ACTION, 16'h0080);
        set_vin(V_LOW);
        cyc(3);
        `CHK(status.output_enable, 1'b0)
        set_vin(V_NORM);
        cyc(40);
        `CHK(status.output_enable, 1'b0)
        clear;
        `CHK(status.output_enable, 1'b1)
        // Three retries, two units per retry interval; only the gap from the first to the second attempt is checked
        wr(CMD_IN_UV_FAULT_ACTION, 16'h0099);
        set_vin(V_LOW);
        cyc(60);
        `CHK({status.attempts, status.retry_active, status.output_enable}, 5'b01100)
        set_vin(V_NORM);
        cyc(10);
        `CHK(status.output_enable, 1'b0)
        clear;
        $display("test disable_retry done");
        // Different unit length, so the unit input really scales the delay
        @(posedge mclk);
        delay_unit_cycles <= 16'h0003;
        for (int c = 0; c < 8; c++) begin
            wr(CMD_IN_UV_FAULT_ACTION, 16'h0040 | 16'(c));
            set_vin(V_LOW);
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (status.output_enable === 1'b1 && n < 600);
            `CHK(n, (3 << c) + 3)
            set_vin(V_NORM);
            clear;
        end
        $display("test delay_codes done");
        wr(CMD_IN_UV_FAULT_ACTION, 16'h0078);
        set_vin(V_LOW);
        cyc(40);
        `CHK({status.retry_active, status.output_enable}, 2'b10)
        @(posedge mclk);
        other_fault_shutdown <= 1'b1;
        cyc(3);
        `CHK({status.retry_active, status.output_enable}, 2'b00)
        set_vin(V_NORM);
        @(posedge mclk);
        other_fault_shutdown <= 1'b0;
        cyc(3);
        `CHK(status.output_enable, 1'b1)
        set_vin(V_LOW);
        cyc(40);
        set_vin(V_NORM);
        cyc(8);
        `CHK({status.retry_active, status.output_enable}, 2'b01)
        $display("test endless_retry done");
        test_done;
    end
endmodule
bind ivfr_input_voltage_fault_response ivfr_props chk (.mclk, .rst, .cmd, .rd_data,
    .rd_valid, .cmd_unsupported, .vin_measured, .delay_unit_cycles, .hybrid_ratio_regulation,
    .op_enable, .other_fault_shutdown, .clear_faults, .status);
`default_nettype wire
